// [rtl/patch_breakpoint_control_reg.sv]
/*
  APB register bank of the patch and breakpoint unit: control word with
  revision, comparator counts, key and global enable; remap base; one
  enable word per comparator. Assumes an APB3 master on i_clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
`include "patch_unit_map.svh"

module patch_breakpoint_control_reg #(
  parameter logic [3:0] REVISION = 4'h0,
  parameter logic [6:0] CODE_COUNT = 7'h06,
  parameter logic [3:0] LIT_COUNT = 4'h2,
  parameter logic REMAP_SUPPORT = 1'b1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire patch_unit_pkg::addr_t i_paddr,
  input wire patch_unit_pkg::word_t i_pwdata,
  output logic o_pready,
  output patch_unit_pkg::word_t o_prdata,
  output logic o_pslverr,
  output logic o_global_enable,
  output logic [23:0] o_remap_base,
  output patch_unit_pkg::comp_vec_t o_comp_active
);
  import patch_unit_pkg::*;

  // ----------------------------------------
  // Implemented comparators
  // ----------------------------------------
  localparam logic [3:0] LIT_EFF = REMAP_SUPPORT ? LIT_COUNT : 4'h0;
  localparam logic [7:0] TOTAL = 8'({1'b0, CODE_COUNT}) + 8'(LIT_EFF);

  patch_gate_if gif ();

  logic global_enable;
  logic [23:0] remap_base;
  comp_vec_t comp_en;
  comp_vec_t comp_mask;
  region_t region;
  logic [7:0] index;
  logic wr_access;
  logic setup;
  word_t next_rdata;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic [7:0] comp_index(input addr_t a);
    addr_t off;
    off = a - `PU_COMP_OFS;
    return off[9:2];
  endfunction

  function automatic region_t decode(input addr_t a);
    if (a[1:0] != 2'h0) begin
      return REG_NONE;
    end else if (a == `PU_CTRL_OFS) begin
      return REG_CTRL;
    end else if (a == `PU_REMAP_OFS) begin
      return REG_REMAP;
    end else if (a >= `PU_COMP_OFS && a[11:10] == 2'h0 &&
                 comp_index(a) < TOTAL) begin
      return REG_COMP;
    end else begin
      return REG_NONE;
    end
  endfunction

  function automatic word_t ctrl_word();
    word_t w;
    w = '0;
    w[`PU_ARCH_MSB:`PU_ARCH_LSB] = REVISION;
    w[`PU_CODE_HI_MSB:`PU_CODE_HI_LSB] = CODE_COUNT[6:4];
    w[`PU_LIT_MSB:`PU_LIT_LSB] = LIT_EFF;
    w[`PU_CODE_LO_MSB:`PU_CODE_LO_LSB] = CODE_COUNT[3:0];
    w[`PU_KEY_BIT] = 1'b0;
    w[`PU_EN_BIT] = global_enable;
    return w;
  endfunction

  assign region = decode(i_paddr);
  assign index = comp_index(i_paddr);
  assign setup = i_psel && !i_penable;
  assign wr_access = i_psel && i_penable && i_pwrite;

  // ----------------------------------------
  // Comparator mask
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < `PU_MAX_COMP; i++) begin
      comp_mask[i] = 8'(i) < TOTAL;
    end
  end

  // ----------------------------------------
  // Global enable
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      global_enable <= `PU_EN_RESET;
    end else if (wr_access && region == REG_CTRL &&
                 i_pwdata[`PU_KEY_BIT]) begin
      global_enable <= i_pwdata[`PU_EN_BIT];
    end
  end

  // ----------------------------------------
  // Remap base
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      remap_base <= `PU_RMP_RESET;
    end else if (wr_access && region == REG_REMAP && REMAP_SUPPORT) begin
      remap_base <= i_pwdata[`PU_RMP_MSB:`PU_RMP_LSB];
    end
  end

  // ----------------------------------------
  // Comparator enables
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      comp_en <= '0;
    end else if (wr_access && region == REG_COMP) begin
      comp_en[index] <= i_pwdata[`PU_CMP_EN_BIT];
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    next_rdata = '0;
    case (region)
      REG_CTRL: begin
        next_rdata = ctrl_word();
      end
      REG_REMAP: begin
        next_rdata[`PU_RMP_SUP_BIT] = REMAP_SUPPORT;
        next_rdata[`PU_RMP_MSB:`PU_RMP_LSB] = remap_base;
      end
      REG_COMP: begin
        next_rdata[`PU_CMP_EN_BIT] = comp_en[index];
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= '0;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_prdata <= i_pwrite ? '0 : next_rdata;
      o_pslverr <= region == REG_NONE;
    end
  end

  assign o_pready = 1'b1;

  // ----------------------------------------
  // Comparator gate
  // ----------------------------------------
  assign gif.global_en = global_enable;
  assign gif.comp_en = comp_en;
  assign gif.comp_mask = comp_mask;

  patch_comp_gate patch_comp_gate_inst (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .gif(gif)
  );

  assign o_comp_active = gif.active;
  assign o_global_enable = global_enable;
  assign o_remap_base = remap_base;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence ctrl_read_s;
    i_psel && !i_penable && !i_pwrite && i_paddr == `PU_CTRL_OFS
      ##1 i_psel && i_penable;
  endsequence

  sequence ctrl_write_s(logic key);
    i_psel && !i_penable && i_pwrite && i_paddr == `PU_CTRL_OFS
      ##1 i_psel && i_penable && i_pwdata[`PU_KEY_BIT] == key;
  endsequence

  rev_field_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ctrl_read_s |-> o_prdata[31:28] == REVISION)
    else $error("revision field wrong");

  code_hi_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ctrl_read_s |-> o_prdata[14:12] == CODE_COUNT[6:4])
    else $error("instruction count high bits wrong");

  code_lo_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ctrl_read_s |-> o_prdata[7:4] == CODE_COUNT[3:0])
    else $error("instruction count low bits wrong");

  lit_field_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ctrl_read_s |-> o_prdata[11:8] == LIT_EFF)
    else $error("literal count field wrong");

  key_raz_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ctrl_read_s |-> o_prdata[1] == 1'b0 && o_prdata[27:15] == '0)
    else $error("key or reserved bits read nonzero");

  key_ignore_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ctrl_write_s(1'b0) |=> $stable(global_enable))
    else $error("write without key changed enable");

  enable_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ctrl_write_s(1'b1) |=> global_enable == $past(i_pwdata[0]))
    else $error("keyed write did not set enable");

  remap_sup_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    setup && !i_pwrite && i_paddr == `PU_REMAP_OFS
      |=> o_prdata[29] == REMAP_SUPPORT)
    else $error("remap support bit wrong");

  reset_clear_a: assert property (@(posedge i_clk_sys)
    $past(i_rst) && i_rst |-> !global_enable && comp_en == '0)
    else $error("reset did not clear the enables");

  unmapped_err_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    setup && region == REG_NONE
      |=> o_pslverr && o_prdata == '0)
    else $error("unmapped access not refused");

  mapped_ok_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    setup && region != REG_NONE |=> !o_pslverr)
    else $error("mapped access refused");

  comp_limit_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    setup && i_paddr[11:10] == 2'h0 && i_paddr[1:0] == 2'h0 &&
      i_paddr >= `PU_COMP_OFS && index >= TOTAL |=> o_pslverr)
    else $error("comparator beyond the count accepted");

  read_stand_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !setup |=> $stable(o_prdata) && $stable(o_pslverr))
    else $error("read data changed outside a setup cycle");

  enable_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !(wr_access && region == REG_CTRL && i_pwdata[`PU_KEY_BIT])
      |=> $stable(global_enable))
    else $error("enable changed without a keyed write");

  remap_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_access && region == REG_REMAP
      |=> remap_base == (REMAP_SUPPORT ?
        $past(i_pwdata[28:5]) : $past(remap_base)))
    else $error("remap base write handled wrongly");

  comp_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_access && region == REG_COMP
      |=> comp_en[$past(index)] == $past(i_pwdata[`PU_CMP_EN_BIT]))
    else $error("comparator enable write lost");

  enable_mask_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (comp_en & ~comp_mask) == '0)
    else $error("enable stored for an absent comparator");

  remap_rsvd_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    setup && !i_pwrite && i_paddr == `PU_REMAP_OFS
      |=> o_prdata[31:30] == 2'h0 && o_prdata[4:0] == 5'h0)
    else $error("remap reserved bits read nonzero");

  write_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    setup && i_pwrite |=> o_prdata == '0)
    else $error("read data not cleared for a write");

  comp_read_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    setup && !i_pwrite && region == REG_COMP
      |=> o_prdata == word_t'($past(comp_en[index])))
    else $error("comparator enable read wrong");
endmodule

`default_nettype wire

// [rtl/patch_comp_gate.sv]
/*
  Gates each comparator by the global enable and its own enable.
  Assumes the register bank drives the enables on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module patch_comp_gate (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  patch_gate_if.gate gif
);
  import patch_unit_pkg::*;

  // ----------------------------------------
  // Gated activity
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      gif.active <= '0;
    end else if (gif.global_en) begin
      gif.active <= gif.comp_en & gif.comp_mask;
    end else begin
      gif.active <= '0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  gate_off_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !gif.global_en |=> gif.active == '0)
    else $error("comparator active while unit disabled");

  gate_on_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    gif.global_en |=> gif.active == $past(gif.comp_en & gif.comp_mask))
    else $error("comparator activity does not follow its enable");

  gate_range_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (gif.active & ~gif.comp_mask) == '0)
    else $error("unimplemented comparator active");
endmodule

`default_nettype wire

// [rtl/patch_gate_if.sv]
/*
  Enables passed from the register bank to the comparator gate, and the
  gated comparator activity passed back. Assumes one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none

interface patch_gate_if;
  import patch_unit_pkg::*;
  logic global_en;
  comp_vec_t comp_en;
  comp_vec_t comp_mask;
  comp_vec_t active;
  modport ctrl (output global_en, comp_en, comp_mask, input active);
  modport gate (input global_en, comp_en, comp_mask, output active);
endinterface

`default_nettype wire

// [rtl/patch_unit_map.svh]
/*
  Register offsets, field positions and limits of the patch unit control
  registers. Assumes inclusion by files that need the numbers.
*/
`ifndef PATCH_UNIT_MAP_SVH
`define PATCH_UNIT_MAP_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define PU_CTRL_OFS 12'h000
`define PU_REMAP_OFS 12'h004
`define PU_COMP_OFS 12'h008

// ----------------------------------------
// Control fields
// ----------------------------------------
`define PU_ARCH_MSB 31
`define PU_ARCH_LSB 28
`define PU_CODE_HI_MSB 14
`define PU_CODE_HI_LSB 12
`define PU_LIT_MSB 11
`define PU_LIT_LSB 8
`define PU_CODE_LO_MSB 7
`define PU_CODE_LO_LSB 4
`define PU_KEY_BIT 1
`define PU_EN_BIT 0
`define PU_EN_RESET 1'b0

// ----------------------------------------
// Remap fields
// ----------------------------------------
`define PU_RMP_SUP_BIT 29
`define PU_RMP_MSB 28
`define PU_RMP_LSB 5
`define PU_RMP_RESET 24'h000000

// ----------------------------------------
// Comparator fields and limits
// ----------------------------------------
`define PU_CMP_EN_BIT 0
`define PU_MAX_CODE 127
`define PU_MAX_LIT 15
`define PU_MAX_COMP 142

`endif

// [rtl/patch_unit_pkg.sv]
/*
  Types shared by the patch unit control registers.
  Assumes the map header supplies the numbers.
*/
`include "patch_unit_map.svh"

package patch_unit_pkg;
  typedef logic [11:0] addr_t;
  typedef logic [31:0] word_t;
  typedef logic [`PU_MAX_COMP-1:0] comp_vec_t;
  typedef enum logic [3:0] {
    REG_NONE = 4'b0001,
    REG_CTRL = 4'b0010,
    REG_REMAP = 4'b0100,
    REG_COMP = 4'b1000
  } region_t;
endpackage

// [testbench/patch_breakpoint_control_reg_tb.sv]
/*
  Self-checking bench of the patch unit control register bank.
  Assumes the map header, the package and the design are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end

module patch_breakpoint_control_reg_tb;
  import patch_unit_pkg::*;
  localparam logic [3:0] VERSION = 4'h1;
  localparam logic [6:0] CODE = 7'h7F;
  localparam logic [3:0] LIT = 4'hF;
  localparam word_t CTRL = {VERSION, 13'h0, CODE[6:4], LIT, CODE[3:0], 4'h0};
  logic clk_sys, rst, psel, penable, pwrite, o_pready, o_pslverr, en;
  logic o_global_enable;
  logic [23:0] o_remap_base;
  addr_t paddr;
  word_t pwdata, o_prdata, d;
  comp_vec_t o_comp_active;
  logic [32:0] exp_q[$];
  logic [32:0] mon_exp;
  int err_count = 0, compares = 0, seed = 86, idx;
  int list[5] = '{0, 126, 127, 141, 5};

  patch_breakpoint_control_reg #(.REVISION(VERSION), .CODE_COUNT(CODE),
    .LIT_COUNT(LIT), .REMAP_SUPPORT(1'b1)) patch_breakpoint_control_reg_inst (
    .i_clk_sys(clk_sys), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .o_global_enable(o_global_enable), .o_remap_base(o_remap_base),
    .o_comp_active(o_comp_active));

  // ----------------------------------------
  // Clock, watchdog, verdict
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #(40 * 4000);
    err_count++;
    end_of_test;
  end

  // ----------------------------------------
  // APB master and result watcher
  // ----------------------------------------
  task automatic apb(input logic w, input addr_t a, input word_t v,
                     input logic [32:0] e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    exp_q.push_back(e);
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (o_pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    if (psel && penable && o_pready === 1'b1) begin
      mon_exp = exp_q.pop_front();
      if (pwrite) `CHK(o_pslverr, mon_exp[32])
      else `CHK({o_pslverr, o_prdata}, mon_exp)
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    en = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, 12'h000, '0, {1'b0, CTRL});
    `CHK(o_global_enable, 1'b0)
    apb(1'b0, 12'h004, '0, {1'b0, 32'h20000000});
    $display("test reset values done");
    for (int i = 0; i < 10; i++) begin
      d = $random(seed);
      d[1] = i[0];
      if (d[1]) en = d[0];
      apb(1'b1, 12'h000, d, 33'h0);
      apb(1'b0, 12'h000, '0, {1'b0, CTRL | {31'h0, en}});
      `CHK(o_global_enable, en)
    end
    $display("test keyed writes done");
    for (int i = 0; i < 5; i++) begin
      idx = (i == 4) ? ($unsigned($random(seed)) % 142) : list[i];
      apb(1'b1, 12'h000, 32'h3, 33'h0);
      apb(1'b1, 12'(8 + 4 * idx), 32'h1, 33'h0);
      @(negedge clk_sys);
      `CHK(o_comp_active, comp_vec_t'(1) << idx)
      @(posedge clk_sys);
      apb(1'b0, 12'(8 + 4 * idx), '0, {1'b0, 32'h1});
      apb(1'b1, 12'h000, 32'h2, 33'h0);
      @(negedge clk_sys);
      `CHK(o_comp_active, comp_vec_t'(0))
      @(posedge clk_sys);
      apb(1'b1, 12'(8 + 4 * idx), 32'h0, 33'h0);
    end
    apb(1'b1, 12'h240, 32'h1, {1'b1, 32'h0});
    apb(1'b0, 12'h240, '0, {1'b1, 32'h0});
    apb(1'b0, 12'h00A, '0, {1'b1, 32'h0});
    $display("test comparators done");
    d = $random(seed);
    apb(1'b1, 12'h004, d, 33'h0);
    apb(1'b0, 12'h004, '0, {1'b0, 3'b001, d[28:5], 5'h0});
    `CHK(o_remap_base, d[28:5])
    $display("test remap done");
    apb(1'b1, 12'h000, 32'h3, 33'h0);
    apb(1'b1, 12'h008, 32'h1, 33'h0);
    rst <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(o_global_enable, 1'b0)
    `CHK(o_comp_active, comp_vec_t'(0))
    @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, 12'h000, '0, {1'b0, CTRL});
    apb(1'b0, 12'h008, '0, {1'b0, 32'h0});
    apb(1'b0, 12'h004, '0, {1'b0, 32'h20000000});
    $display("test mid-run reset done");
    end_of_test;
  end
endmodule

`default_nettype wire
